// ==== timer_output_and_flag_logic_tb.sv ====
// testbench: timer output and flag block against its pin model
module timer_output_and_flag_logic_tb
    import tofl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    tofl_bus_t bus = '0;
    logic timer_group_b_input = 1'b0;
    logic extLevel = 1'b0;
    logic evtStart = 1'b0;
    logic [7:0] evtNum = 8'h00;
    logic evtSlow = 1'b0;
    logic [15:0] rdData;
    logic evtBusy, groupA, pinLevel, pulseOut, pulseOe, irq;
    int err_count = 0;
    int num_checks = 0;
    int divs[4] = '{DIV_STEP0, DIV_STEP1, DIV_STEP2, DIV_STEP3};

    always #4 clk_sys = !clk_sys;

    tofl_timer tofl_timer_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .rdData(rdData),
        .timer_group_a_input(groupA), .timer_group_b_input(timer_group_b_input),
        .pulseOutPin(pinLevel), .timer_pulse_output(pulseOut),
        .timer_pulse_output_oe(pulseOe), .irq(irq));
    tofl_pin_model tofl_pin_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .evtStart(evtStart),
        .evtNum(evtNum), .evtSlow(evtSlow), .evtBusy(evtBusy), .timer_group_a_input(groupA),
        .timer_pulse_output(pulseOut), .timer_pulse_output_oe(pulseOe), .extLevel(extLevel),
        .pulseOutPin(pinLevel));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] gotv);
        num_checks++;
        if (gotv !== expv) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, expv, gotv);
        end
    endtask : chk

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask : reg_wr

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] expv);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 chk(what, expv, rdData);
    endtask : rd_chk

    // counts edges until the pulse output shows the wanted level
    task automatic wait_out(input logic v, output int n);
        n = 0;
        #1;
        while (pulseOut !== v && n < 2000) begin
            @(posedge clk_sys);
            #1 n++;
        end
    endtask : wait_out

    function automatic logic [15:0] ctl(input tofl_mode_t m, input logic [1:0] cs,
        input logic up, input logic p8);
        ctl = 16'h0000;
        ctl[CTRL_MODE_LSB +: 2] = m;
        ctl[CTRL_UP_BIT] = up;
        ctl[CTRL_PWM8_BIT] = p8;
        ctl[CTRL_CLKSEL_LSB +: 2] = cs;
        ctl[CTRL_RUN_BIT] = 1'b1;
    endfunction : ctl

    task automatic prime(input logic [15:0] rl);
        reg_wr(ADDR_CTRL, 16'h0000);
        reg_wr(ADDR_STATUS, 16'h0003);
        reg_wr(ADDR_RELOAD, rl);
    endtask : prime

    task automatic pulses(input logic [7:0] k, input logic slow);
        @(posedge clk_sys);
        evtNum <= k;
        evtSlow <= slow;
        evtStart <= 1'b1;
        @(posedge clk_sys);
        evtStart <= 1'b0;
        #1;
        for (int w = 0; w < 400 && evtBusy; w++) @(posedge clk_sys);
        repeat (8) @(posedge clk_sys);
    endtask : pulses

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd_chk("ctrl", ADDR_CTRL, 16'h0000);
        rd_chk("reload", ADDR_RELOAD, 16'hffff);
        rd_chk("count", ADDR_COUNT, 16'hffff);
        rd_chk("status", ADDR_STATUS, 16'h0000);
        rd_chk("mask", ADDR_MASK, 16'h0000);
        rd_chk("dir", ADDR_PORTDIR, 16'h0000);
        reg_wr(4'h9, 16'hffff);
        rd_chk("unmapped", 4'h9, 16'h0000);
    endtask : t_reset

    task automatic t_timer(input logic [15:0] rl);
        int n;
        prime(rl);
        reg_wr(ADDR_MASK, 16'h0001);
        reg_wr(ADDR_CTRL, ctl(MODE_TIMER, 2'h0, 1'b0, 1'b0));
        wait_out(1'b1, n);
        chk("irq at toggle", 16'h0001, 16'(irq));
        wait_out(1'b0, n);
        chk("timer half period", 16'(2 * (rl + 1)), 16'(n));
        reg_wr(ADDR_CTRL, 16'h0000);
        reg_wr(ADDR_STATUS, 16'h0001);
        rd_chk("status cleared", ADDR_STATUS, 16'h0000);
        chk("irq cleared", 16'h0000, 16'(irq));
        reg_wr(ADDR_MASK, 16'h0000);
        reg_wr(ADDR_CTRL, ctl(MODE_TIMER, 2'h0, 1'b0, 1'b0));
        wait_out(1'b1, n);
        repeat (2) @(posedge clk_sys);
        #1 chk("irq masked", 16'h0000, 16'(irq));
        rd_chk("status sticky", ADDR_STATUS, 16'h0001);
    endtask : t_timer

    task automatic t_event(input logic up, input logic [15:0] rl, input logic slow);
        prime(rl);
        reg_wr(ADDR_CTRL, ctl(MODE_EVENT, 2'h0, up, 1'b0));
        pulses(8'h02, slow);
        rd_chk("event count", ADDR_COUNT, up ? rl + 16'h2 : rl - 16'h2);
        chk("no toggle yet", 16'h0000, 16'(pulseOut));
        pulses(8'h01, slow);
        chk("toggle after terminal", 16'h0001, 16'(pulseOut));
        rd_chk("reloaded count", ADDR_COUNT, rl);
        rd_chk("event flag", ADDR_STATUS, 16'h0001);
    endtask : t_event

    task automatic t_oneshot();
        int n;
        prime(16'h0004);
        reg_wr(ADDR_MASK, 16'h0001);
        reg_wr(ADDR_CTRL, ctl(MODE_ONESHOT, 2'h0, 1'b0, 1'b0));
        rd_chk("no flag before start", ADDR_STATUS, 16'h0000);
        reg_wr(ADDR_CTRL, ctl(MODE_ONESHOT, 2'h0, 1'b0, 1'b0) | (16'h0001 << CTRL_START_BIT));
        wait_out(1'b1, n);
        chk("flag not on rise", 16'h0000, 16'(irq));
        wait_out(1'b0, n);
        chk("oneshot width", 16'(5 * divs[0]), 16'(n));
        @(posedge clk_sys);
        #1 chk("irq after fall", 16'h0001, 16'(irq));
    endtask : t_oneshot

    task automatic t_pwm();
        int n;
        logic [7:0] hi[2] = '{8'h02, 8'h03};
        logic [7:0] lo[2] = '{8'h01, 8'h03};
        for (int cs = 0; cs < 4; cs++) begin
            prime(16'h0003);
            reg_wr(ADDR_CTRL, ctl(MODE_PWM, 2'(cs), 1'b0, 1'b0));
            wait_out(1'b1, n);
            wait_out(1'b0, n);
            chk("pwm16 high", 16'(3 * divs[cs]), 16'(n));
            wait_out(1'b1, n);
            chk("pwm16 low", 16'(divs[cs]), 16'(n));
            rd_chk("pwm flag", ADDR_STATUS, 16'h0001);
        end
        for (int k = 0; k < 2; k++) begin
            prime({hi[k], lo[k]});
            reg_wr(ADDR_CTRL, ctl(MODE_PWM, 2'h0, 1'b0, 1'b1));
            wait_out(1'b1, n);
            wait_out(1'b0, n);
            chk("pwm8 high", 16'(hi[k] * (lo[k] + 1) * divs[0]), 16'(n));
        end
        reg_wr(ADDR_CTRL, 16'h0000);
    endtask : t_pwm

    task automatic t_port();
        @(posedge clk_sys);
        extLevel <= 1'b1;
        timer_group_b_input <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rd_chk("pins as inputs", ADDR_PORTREAD, 16'h0006);
        reg_wr(ADDR_PORTLATCH, 16'h0001);
        reg_wr(ADDR_PORTDIR, 16'h0007);
        rd_chk("pins as outputs", ADDR_PORTREAD, 16'h0001);
        chk("output enable", 16'h0001, 16'(pulseOe));
        reg_wr(ADDR_PORTLATCH, 16'h0006);
        reg_wr(ADDR_PORTDIR, 16'h0003);
        repeat (4) @(posedge clk_sys);
        rd_chk("mixed directions", ADDR_PORTREAD, 16'h0006);
    endtask : t_port

    // ----------------------------------------
    // sequence and verdict
    // ----------------------------------------
    task automatic tally_and_finish();
        if (err_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_timer(16'h0003);
        t_timer(16'h0100);
        t_event(1'b0, 16'h0002, 1'b0);
        t_event(1'b1, 16'hfffd, 1'b1);
        t_oneshot();
        t_pwm();
        t_port();
        tally_and_finish();
    end

    initial begin
        repeat (50000) @(posedge clk_sys);
        err_count++;
        tally_and_finish();
    end
endmodule : timer_output_and_flag_logic_tb

// ==== tofl_pin_model.sv ====
// partner model: count pulse source and load on the pulse output pin
module tofl_pin_model
    import tofl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // pulse requests
    input wire logic evtStart,
    input wire logic [7:0] evtNum,
    input wire logic evtSlow,
    output logic evtBusy,
    output logic timer_group_a_input,
    // output pin load
    input wire logic timer_pulse_output,
    input wire logic timer_pulse_output_oe,
    input wire logic extLevel,
    output logic pulseOutPin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] pulsesLeft_q;
    logic [3:0] phase_q;
    wire [3:0] halfEnd = evtSlow ? 4'h9 : 4'h3;

    // a pulse ends when its high phase is done
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pulsesLeft_q <= 8'h00;
            phase_q <= 4'h0;
            timer_group_a_input <= 1'b0;
        end else if (evtStart) begin
            pulsesLeft_q <= evtNum;
            phase_q <= 4'h0;
        end else if (pulsesLeft_q != 8'h00) begin
            if (phase_q == halfEnd) begin
                phase_q <= 4'h0;
                timer_group_a_input <= !timer_group_a_input;
                if (timer_group_a_input) begin
                    pulsesLeft_q <= pulsesLeft_q - 8'h01;
                end
            end else begin
                phase_q <= phase_q + 4'h1;
            end
        end
    end

    assign evtBusy = (pulsesLeft_q != 8'h00);
    // undriven pin follows whatever the outside load holds it at
    assign pulseOutPin = timer_pulse_output_oe ? timer_pulse_output : extLevel;
endmodule : tofl_pin_model

// ==== tofl_pkg.sv ====
// package: constants and types of the timer output and flag block
package tofl_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_RELOAD = 4'h1;
    localparam logic [3:0] ADDR_COUNT = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_MASK = 4'h4;
    localparam logic [3:0] ADDR_PORTDIR = 4'h5;
    localparam logic [3:0] ADDR_PORTLATCH = 4'h6;
    localparam logic [3:0] ADDR_PORTREAD = 4'h7;

    // ----------------------------------------
    // control field positions
    // ----------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_UP_BIT = 2;
    localparam int CTRL_PWM8_BIT = 3;
    localparam int CTRL_CLKSEL_LSB = 4;
    localparam int CTRL_RUN_BIT = 6;
    localparam int CTRL_EDGE_BIT = 7;
    localparam int CTRL_START_BIT = 8;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [15:0] RESET_CTRL = 16'h0000;
    localparam logic [15:0] RESET_RELOAD = 16'hffff;
    localparam logic [15:0] RESET_COUNT = 16'hffff;
    localparam logic [1:0] RESET_STATUS = 2'h0;
    localparam logic [1:0] RESET_MASK = 2'h0;
    localparam logic [2:0] RESET_PORT = 3'h0;

    // ----------------------------------------
    // counts and terminal values
    // ----------------------------------------
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_ONES = 16'hffff;
    localparam logic [7:0] HALF_ZERO = 8'h00;
    localparam logic [7:0] HALF_ONES = 8'hff;
    localparam logic [4:0] DIV_STEP0 = 5'h02;
    localparam logic [4:0] DIV_STEP1 = 5'h08;
    localparam logic [4:0] DIV_STEP2 = 5'h10;
    localparam logic [4:0] DIV_STEP3 = 5'h1f;

    // ----------------------------------------
    // status bits
    // ----------------------------------------
    localparam int STAT_TIMER_BIT = 0;
    localparam int STAT_GROUPB_BIT = 1;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        MODE_TIMER,
        MODE_EVENT,
        MODE_ONESHOT,
        MODE_PWM
    } tofl_mode_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } tofl_bus_t;

endpackage : tofl_pkg

// ==== tofl_sync.sv ====
// two flip-flop synchroniser for a group of pin levels
module tofl_sync
    import tofl_pkg::*;
#(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    if (WIDTH < 1) begin : gBadWidth
        $error("tofl_sync: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] stage1_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stage1_q <= '0;
            syncOut <= '0;
        end else begin
            stage1_q <= asyncIn;
            syncOut <= stage1_q;
        end
    end

endmodule : tofl_sync

// ==== tofl_timer.sv ====
// timer output pulse, flag and port read-back logic
// ----------------------------------------
// ----------------------------------------
//
// The register addresses and strobed register access were chosen for this implementation.
module tofl_timer
    import tofl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire tofl_bus_t bus,
    output logic [15:0] rdData,
    // timer pins
    input wire logic timer_group_a_input,
    input wire logic timer_group_b_input,
    input wire logic pulseOutPin,
    output logic timer_pulse_output,
    output logic timer_pulse_output_oe,
    // interrupt
    output logic irq
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [15:0] ctrl_q;
    logic [15:0] reload_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [7:0] prePwm_q;
    logic [7:0] prePwm_d;
    logic [1:0] status_q;
    logic [1:0] mask_q;
    logic [2:0] portDir_q;
    logic [2:0] portLatch_q;
    logic out_q;
    logic out_d;
    logic [4:0] div_q;
    logic [1:0] pinEdge_q;
    logic pwmHigh_q;
    logic pwmHigh_d;
    logic oneshotRun_q;
    logic oneshotRun_d;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0] pinSync;

    tofl_sync #(.WIDTH(3)) uSync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .asyncIn({pulseOutPin, timer_group_b_input, timer_group_a_input}),
        .syncOut(pinSync)
    );

    // ----------------------------------------
    // decode
    // ----------------------------------------
    tofl_mode_t mode;
    wire upCount = ctrl_q[CTRL_UP_BIT];
    wire pwm8 = ctrl_q[CTRL_PWM8_BIT];
    wire [1:0] clkSel = ctrl_q[CTRL_CLKSEL_LSB +: 2];
    wire running = ctrl_q[CTRL_RUN_BIT];
    wire fallEdge = ctrl_q[CTRL_EDGE_BIT];
    assign mode = tofl_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
    wire wrCtrl = bus.wr && bus.addr == ADDR_CTRL;
    wire wrReload = bus.wr && bus.addr == ADDR_RELOAD;
    wire wrStatus = bus.wr && bus.addr == ADDR_STATUS;
    wire wrMask = bus.wr && bus.addr == ADDR_MASK;
    wire wrDir = bus.wr && bus.addr == ADDR_PORTDIR;
    wire wrLatch = bus.wr && bus.addr == ADDR_PORTLATCH;
    wire startPulse = wrCtrl && bus.wdata[CTRL_START_BIT];

    // ----------------------------------------
    // clock source selection, one of four
    // ----------------------------------------
    wire [4:0] divEnd = clkSel == 2'h0 ? DIV_STEP0 :
                        clkSel == 2'h1 ? DIV_STEP1 :
                        clkSel == 2'h2 ? DIV_STEP2 : DIV_STEP3;
    wire srcTick = div_q >= divEnd - 5'h01;

    // ----------------------------------------
    // count edge: internal source or synced pin
    // ----------------------------------------
    wire pinNow = pinSync[0];
    wire pinRise = pinNow && !pinEdge_q[0];
    wire pinFall = !pinNow && pinEdge_q[0];
    wire pinEdgeHit = fallEdge ? pinFall : pinRise;
    wire countEdge = running && (mode == MODE_EVENT ? pinEdgeHit : srcTick);
    wire countUp = mode == MODE_EVENT && upCount;
    wire atTerminal = countUp ? count_q == COUNT_ONES : count_q == COUNT_ZERO;
    wire terminalHit = countEdge && atTerminal &&
                       (mode == MODE_TIMER || mode == MODE_EVENT);

    // ----------------------------------------
    // pwm and one-shot
    // ----------------------------------------
    wire pwmMode = mode == MODE_PWM;
    wire [7:0] preEnd = reload_q[7:0];
    wire preWrap = prePwm_q == HALF_ZERO;
    wire pwmStep = running && srcTick && (!pwm8 || preWrap);
    wire [7:0] count8 = count_q[7:0];
    wire pwmPeriodEnd = pwm8 ? count8 == HALF_ZERO : count_q == COUNT_ZERO;
    wire outFall = out_q && !out_d;

    always_comb begin
        count_d = count_q;
        prePwm_d = prePwm_q;
        out_d = out_q;
        pwmHigh_d = pwmHigh_q;
        oneshotRun_d = oneshotRun_q;
        unique case (mode)
            MODE_TIMER, MODE_EVENT: begin
                if (terminalHit) begin
                    count_d = reload_q;
                    out_d = !out_q;
                end else if (countEdge) begin
                    count_d = countUp ? count_q + 16'h0001 : count_q - 16'h0001;
                end
            end
            MODE_ONESHOT: begin
                if (startPulse && running) begin
                    oneshotRun_d = 1'b1;
                    count_d = reload_q;
                    out_d = 1'b1;
                end else if (oneshotRun_q && srcTick) begin
                    if (count_q == COUNT_ZERO) begin
                        oneshotRun_d = 1'b0;
                        out_d = 1'b0;
                    end else begin
                        count_d = count_q - 16'h0001;
                    end
                end
            end
            MODE_PWM: begin
                if (running && srcTick) begin
                    prePwm_d = preWrap ? preEnd : prePwm_q - 8'h01;
                end
                if (pwmStep) begin
                    if (pwmPeriodEnd) begin
                        pwmHigh_d = 1'b1;
                        out_d = 1'b1;
                        if (pwm8) begin
                            count_d = {8'h00, reload_q[15:8]};
                        end else begin
                            count_d = reload_q;
                        end
                    end else begin
                        count_d = count_q - 16'h0001;
                        if (count_q == 16'h0001) begin
                            pwmHigh_d = 1'b0;
                            out_d = 1'b0;
                        end
                    end
                end
            end
        endcase
        if (!running) begin
            out_d = 1'b0;
            pwmHigh_d = 1'b0;
            oneshotRun_d = 1'b0;
        end
    end

    // ----------------------------------------
    // events into sticky status; set wins over clear
    // ----------------------------------------
    wire flagSet = terminalHit ||
                   ((mode == MODE_ONESHOT || pwmMode) && outFall);
    wire groupBEdge = pinSync[1] && !pinEdge_q[1];
    wire [1:0] events = {groupBEdge && running, flagSet};
    wire [1:0] statusClr = wrStatus ? bus.wdata[1:0] : 2'h0;
    wire [1:0] status_d = (status_q & ~statusClr) | events;

    // ----------------------------------------
    // read-back
    // ----------------------------------------
    wire [2:0] portRead = (portDir_q & portLatch_q) | (~portDir_q & pinSync);
    wire [15:0] rd_d = bus.addr == ADDR_CTRL ? ctrl_q :
                       bus.addr == ADDR_RELOAD ? reload_q :
                       bus.addr == ADDR_COUNT ? count_q :
                       bus.addr == ADDR_STATUS ? {14'h0000, status_q} :
                       bus.addr == ADDR_MASK ? {14'h0000, mask_q} :
                       bus.addr == ADDR_PORTDIR ? {13'h0000, portDir_q} :
                       bus.addr == ADDR_PORTLATCH ? {13'h0000, portLatch_q} :
                       bus.addr == ADDR_PORTREAD ? {13'h0000, portRead} : 16'h0000;

    // ----------------------------------------
    // state
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_q <= RESET_CTRL;
            reload_q <= RESET_RELOAD;
            count_q <= RESET_COUNT;
            prePwm_q <= HALF_ONES;
            div_q <= 5'h00;
            pinEdge_q <= 2'h0;
            out_q <= 1'b0;
            pwmHigh_q <= 1'b0;
            oneshotRun_q <= 1'b0;
        end else begin
            ctrl_q <= wrCtrl ? {7'h00, 1'b0, bus.wdata[7:0]} : ctrl_q;
            reload_q <= wrReload ? bus.wdata : reload_q;
            count_q <= (wrReload && !running) ? bus.wdata : count_d;
            prePwm_q <= prePwm_d;
            // restart on reprogram so the first tick is a full period away
            div_q <= (srcTick || wrCtrl) ? 5'h00 : div_q + 5'h01;
            pinEdge_q <= pinSync[1:0];
            out_q <= out_d;
            pwmHigh_q <= pwmHigh_d;
            oneshotRun_q <= oneshotRun_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            status_q <= RESET_STATUS;
            mask_q <= RESET_MASK;
            portDir_q <= RESET_PORT;
            portLatch_q <= RESET_PORT;
            rdData <= 16'h0000;
            irq <= 1'b0;
            timer_pulse_output <= 1'b0;
            timer_pulse_output_oe <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q <= wrMask ? bus.wdata[1:0] : mask_q;
            portDir_q <= wrDir ? bus.wdata[2:0] : portDir_q;
            portLatch_q <= wrLatch ? bus.wdata[2:0] : portLatch_q;
            rdData <= bus.rd ? rd_d : 16'h0000;
            irq <= |(status_d & mask_q);
            timer_pulse_output <= out_d;
            timer_pulse_output_oe <= portDir_q[2];
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_toggle_at_term: assert property (@(posedge clk_sys) disable iff (!rst_n)
        terminalHit |=> out_q != $past(out_q))
        else $error("output did not toggle at terminal count");
    chk_flag_with_toggle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        terminalHit |=> status_q[STAT_TIMER_BIT])
        else $error("flag not set with output toggle");
    chk_flag_on_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode == MODE_PWM && $fell(out_q) && $stable(mode)) |-> status_q[STAT_TIMER_BIT])
        else $error("flag not set on output fall");
    chk_read_pin_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (bus.rd && bus.addr == ADDR_PORTREAD && !portDir_q[0]) |=> rdData[0] == $past(pinSync[0]))
        else $error("input pin read-back wrong");
    chk_read_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (bus.rd && bus.addr == ADDR_PORTREAD && portDir_q[1]) |=> rdData[1] == $past(portLatch_q[1]))
        else $error("output pin read-back wrong");
    chk_pwm8_high_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (pwmMode && pwm8 && pwmStep && pwmPeriodEnd && !wrReload) |=>
            count_q == {8'h00, $past(reload_q[15:8])} && out_q && pwmHigh_q)
        else $error("8-bit pwm high phase load wrong");
    chk_prescale_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (pwmMode && running && srcTick && preWrap && !wrReload) |=> prePwm_q == $past(reload_q[7:0]))
        else $error("8-bit pwm divider reload wrong");
    chk_full_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode == MODE_TIMER && countEdge && !atTerminal && !wrReload) |=>
            count_q == $past(count_q) - 16'h0001)
        else $error("16-bit counter step wrong");
    chk_reload_term: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (terminalHit && !wrReload) |=> count_q == $past(reload_q))
        else $error("counter not reloaded at terminal");
    chk_tick_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (srcTick && clkSel == 2'h1 && !wrCtrl) |=> (!srcTick || clkSel != 2'h1) [*7])
        else $error("clock source tick spacing wrong");

endmodule : tofl_timer
